// ===== tdt_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tdt_ctrl
  import tdt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic        irq
);
  tdt_bus_t               bus_state;
  logic                   wr_pend;
  logic [WADDR_W-1:0]     wr_word;
  logic [WADDR_W-1:0]     rd_word;
  logic                   mode16;
  logic                   rsv_a;
  logic [1:0]             csel_a;
  logic [1:0]             csel_b;
  logic                   run_a;
  logic                   run_b;
  logic                   ie_a;
  logic                   ie_b;
  logic                   pend_a;
  logic                   pend_b;
  logic [STS_W-1:0]       sts;
  logic [STS_W-1:0]       msk;
  logic [7:0]             div;
  logic [7:0]             cnt_a;
  logic [7:0]             cnt_b;
  logic                   wrap_a;
  logic                   wrap_b;
  logic                   addr_ok;
  logic                   wr_a;
  logic                   wr_b;
  logic                   wr_sts;
  logic                   wr_msk;
  logic                   tick_a;
  logic                   tick_b;
  logic                   inc_a;
  logic                   inc_b;
  logic                   clr_a;
  logic                   clr_b;
  logic                   ev_a;
  logic                   ev_b;
  logic [7:0]             ctl_a_rd;
  logic [7:0]             ctl_b_rd;
  logic [31:0]            next_rdata;

  function automatic logic hit(input logic [WADDR_W-1:0] w, input logic [7:0] idx);
    hit = (w == {{(WADDR_W-8){1'b0}}, idx});
  endfunction : hit

  function automatic logic tick_of(input logic [7:0] d, input logic [1:0] sel);
    logic [7:0] m;
    m = DIV256_MASK;
    case (sel)
      CSEL_DIV256: m = DIV256_MASK;
      CSEL_DIV64:  m = DIV64_MASK;
      CSEL_DIV8:   m = DIV8_MASK;
      default:     m = DIV1_MASK;
    endcase
    tick_of = ((d & m) == m);
  endfunction : tick_of

  // Bus slave: writes take no wait state, reads take one
  assign addr_ok = hsel && hready && htrans[1] && (haddr[1:0] == 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= TDT_BUS_IDLE;
      hreadyout <= 1'b1;
      wr_pend   <= 1'b0;
      wr_word   <= '0;
      rd_word   <= '0;
      hrdata    <= '0;
      hresp     <= 1'b0;
    end else begin
      case (bus_state)
        TDT_BUS_IDLE: begin
          wr_pend <= addr_ok && hwrite;
          if (addr_ok) begin
            wr_word <= haddr[31:2];
            rd_word <= haddr[31:2];
          end
          if (addr_ok && !hwrite) begin
            bus_state <= TDT_BUS_RDWAIT;
            hreadyout <= 1'b0;
          end
        end
        default: begin
          wr_pend   <= 1'b0;
          hrdata    <= next_rdata;
          hreadyout <= 1'b1;
          bus_state <= TDT_BUS_IDLE;
        end
      endcase
    end
  end

  assign wr_a   = wr_pend && hit(wr_word, IDX_CTL_A);
  assign wr_b   = wr_pend && hit(wr_word, IDX_CTL_B);
  assign wr_sts = wr_pend && hit(wr_word, IDX_STATUS);
  assign wr_msk = wr_pend && hit(wr_word, IDX_MASK);

  // Clear bit is not stored, so it always reads zero
  assign ctl_a_rd = {mode16, rsv_a, csel_a, 1'b0, run_a, ie_a, pend_a};
  assign ctl_b_rd = {2'h0, csel_b, 1'b0, run_b, ie_b, pend_b};

  always_comb begin
    next_rdata = '0;
    if (hit(rd_word, IDX_CTL_A)) begin
      next_rdata[7:0] = ctl_a_rd;
    end else if (hit(rd_word, IDX_CTL_B)) begin
      next_rdata[7:0] = ctl_b_rd;
    end else if (hit(rd_word, IDX_COUNT)) begin
      next_rdata[15:0] = {cnt_b, cnt_a};
    end else if (hit(rd_word, IDX_STATUS)) begin
      next_rdata[STS_W-1:0] = sts;
    end else if (hit(rd_word, IDX_MASK)) begin
      next_rdata[STS_W-1:0] = msk;
    end
  end

  // Control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode16 <= 1'b0;
      rsv_a  <= 1'b0;
      csel_a <= CSEL_DIV256;
      run_a  <= 1'b0;
      ie_a   <= 1'b0;
    end else if (wr_a) begin
      mode16 <= hwdata[CTL_MODE];
      rsv_a  <= hwdata[CTL_RSV];
      csel_a <= hwdata[CTL_CSEL_HI:CTL_CSEL_LO];
      run_a  <= hwdata[CTL_RUN];
      ie_a   <= hwdata[CTL_IE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csel_b <= CSEL_DIV256;
      run_b  <= 1'b0;
      ie_b   <= 1'b0;
    end else if (wr_b) begin
      csel_b <= hwdata[CTL_CSEL_HI:CTL_CSEL_LO];
      run_b  <= hwdata[CTL_RUN];
      ie_b   <= hwdata[CTL_IE];
    end
  end

  // Free-running prescaler shared by both timers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= '0;
    end else begin
      div <= div + CNT_ONE;
    end
  end

  assign tick_a = tick_of(div, csel_a);
  assign tick_b = tick_of(div, csel_b);
  assign inc_a  = run_a && tick_a;
  // Joined mode: high byte counts on low byte carry under A controls
  assign inc_b  = mode16 ? wrap_a : (run_b && tick_b);
  assign clr_a  = wr_a && hwdata[CTL_CLR];
  // Joined clear also follows a mode bit written in the same access
  assign clr_b  = (clr_a && (mode16 || hwdata[CTL_MODE]))
               || (!mode16 && wr_b && hwdata[CTL_CLR]);
  assign ev_a   = mode16 ? wrap_b : wrap_a;
  assign ev_b   = !mode16 && wrap_b;

  tdt_cnt8 u_cnt_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (clr_a),
    .inc     (inc_a),
    .count   (cnt_a),
    .wrap    (wrap_a)
  );

  tdt_cnt8 u_cnt_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (clr_b),
    .inc     (inc_b),
    .count   (cnt_b),
    .wrap    (wrap_b)
  );

  // Pending flags: overflow sets, writing zero clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end else begin
      if (ev_a) begin
        pend_a <= 1'b1;
      end else if (wr_a && !hwdata[CTL_PEND]) begin
        pend_a <= 1'b0;
      end
      if (ev_b) begin
        pend_b <= 1'b1;
      end else if (wr_b && !hwdata[CTL_PEND]) begin
        pend_b <= 1'b0;
      end
    end
  end

  // Sticky requests, gated by each timer's enable, cleared by writing one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts <= '0;
    end else begin
      if (ev_a && ie_a) begin
        sts[STS_A] <= 1'b1;
      end else if (wr_sts && hwdata[STS_A]) begin
        sts[STS_A] <= 1'b0;
      end
      if (ev_b && ie_b) begin
        sts[STS_B] <= 1'b1;
      end else if (wr_sts && hwdata[STS_B]) begin
        sts[STS_B] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msk <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_msk) begin
        msk <= hwdata[STS_W-1:0];
      end
      irq <= |(sts & msk);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_clear_a_zero: assert property (clr_a |=> cnt_a == 8'h00)
    else $error("counter A not cleared");
  a_clear_b_zero: assert property (!mode16 && wr_b && hwdata[CTL_CLR] |=> cnt_b == 8'h00)
    else $error("counter B not cleared");
  a_run_a_hold: assert property (!run_a && !clr_a |=> $stable(cnt_a))
    else $error("counter A moved while stopped");
  a_run_b_hold: assert property (!mode16 && !run_b && !clr_b |=> $stable(cnt_b))
    else $error("counter B moved while stopped");
  a_div_gate_a: assert property (!$past(clr_a) && $changed(cnt_a) |-> $past(tick_a) && $past(run_a))
    else $error("counter A stepped off its tick");
  a_carry_join: assert property (mode16 && wrap_a |=> cnt_b == 8'($past(cnt_b) + 8'h01))
    else $error("high byte missed carry");
  a_req_gate: assert property ($rose(sts[STS_A]) |-> $past(ie_a) && $past(ev_a))
    else $error("request raised while disabled");
  a_pend_set: assert property (ev_a |=> pend_a ##1 (pend_a || $past(wr_a)))
    else $error("pending flag not set");
  a_pend_w1: assert property (wr_b && hwdata[CTL_PEND] && pend_b |=> pend_b)
    else $error("writing one cleared pending");
  a_b_unused: assert property (hreadyout && $past(bus_state) == TDT_BUS_RDWAIT &&
                               hit(rd_word, IDX_CTL_B) |-> hrdata[7:6] == 2'h0)
    else $error("unused control B bits read nonzero");
  a_read_wait: assert property (bus_state == TDT_BUS_IDLE && addr_ok && !hwrite
                                |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_join_clr: assert property (clr_a && (mode16 || hwdata[CTL_MODE]) |=> cnt_b == 8'h00)
    else $error("joined clear missed high byte");
  a_pend_clear: assert property (wr_a && !hwdata[CTL_PEND] && !ev_a |=> !pend_a)
    else $error("pending flag not cleared");
  a_pend_w1_a: assert property (wr_a && hwdata[CTL_PEND] && pend_a |=> pend_a)
    else $error("writing one cleared pending A");
  a_irq_follow: assert property (|(sts & msk) |=> irq)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (!(|(sts & msk)) |=> !irq)
    else $error("interrupt raised while masked");

  c_mode16_ovf: cover property (mode16 && ev_a);
  c_clear_run: cover property (clr_a && run_a);
  c_irq_high: cover property ($rose(irq));
  c_pend_clear: cover property (pend_b ##1 !pend_b);
  c_join_carry: cover property (mode16 && wrap_a);
endmodule : tdt_ctrl
`default_nettype wire

// ===== tdt_pkg.sv
`default_nettype none
package tdt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTL_A   = 8'hd2;
  localparam logic [7:0]  IDX_CTL_B   = 8'hd3;
  localparam logic [7:0]  IDX_COUNT   = 8'hd4;
  localparam logic [7:0]  IDX_STATUS  = 8'hd5;
  localparam logic [7:0]  IDX_MASK    = 8'hd6;
  localparam int          WADDR_W     = 30;

  // Control register fields
  localparam int          CTL_MODE    = 7;
  localparam int          CTL_RSV     = 6;
  localparam int          CTL_CSEL_HI = 5;
  localparam int          CTL_CSEL_LO = 4;
  localparam int          CTL_CLR     = 3;
  localparam int          CTL_RUN     = 2;
  localparam int          CTL_IE      = 1;
  localparam int          CTL_PEND    = 0;

  // Status and mask fields
  localparam int          STS_W       = 2;
  localparam int          STS_A       = 0;
  localparam int          STS_B       = 1;

  localparam logic [1:0]  CSEL_DIV256 = 2'h0;
  localparam logic [1:0]  CSEL_DIV64  = 2'h1;
  localparam logic [1:0]  CSEL_DIV8   = 2'h2;
  localparam logic [1:0]  CSEL_DIV1   = 2'h3;
  localparam logic [7:0]  DIV256_MASK = 8'hff;
  localparam logic [7:0]  DIV64_MASK  = 8'h3f;
  localparam logic [7:0]  DIV8_MASK   = 8'h07;
  localparam logic [7:0]  DIV1_MASK   = 8'h00;

  localparam logic [7:0]  CNT_MAX     = 8'hff;
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

  typedef enum logic {
    TDT_BUS_IDLE   = 1'b0,
    TDT_BUS_RDWAIT = 1'b1
  } tdt_bus_t;
endpackage : tdt_pkg
`default_nettype wire

// ===== tdt_cnt8.sv
`timescale 1ns/1ns
`default_nettype none
module tdt_cnt8
  import tdt_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clr,
  input  wire logic       inc,
  output var  logic [7:0] count,
  output      logic       wrap
);
  // Clear wins over counting
  assign wrap = inc && !clr && (count == CNT_MAX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (clr) begin
      count <= '0;
    end else if (inc) begin
      count <= count + CNT_ONE;
    end
  end
endmodule : tdt_cnt8
`default_nettype wire

// ===== test_dual_8bit_timer_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_dual_8bit_timer_control;
  import tdt_pkg::*;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  wire  logic  hready;
  wire  logic [31:0] hrdata;
  wire  logic  hreadyout;
  wire  logic  hresp;
  wire  logic  irq;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          seed     = 32'h562e;
  logic [31:0] lo_q[$];
  logic [31:0] hi_q[$];
  logic        rd_pend  = 1'b0;
  int          divs[4]  = '{256, 64, 8, 1};

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  tdt_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if ((got >= lo && got <= hi && hresp == 1'b0) !== 1'b1) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk

  // Read completion: oldest noted expectation is compared
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      chk(hrdata, lo_q.pop_front(), hi_q.pop_front());
      rd_pend = 1'b0;
    end
    if (hsel && hready && htrans[1] && !hwrite) rd_pend = 1'b1;
  end

  task automatic wait_rdy;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_errors++;
    end_sim();
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [31:0] lo, input logic [31:0] hi);
    hsel   <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    if (!wr) begin
      lo_q.push_back(lo);
      hi_q.push_back(hi);
    end
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy();
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] lo, input logic [31:0] hi);
    bus(1'b0, idx, 32'h0, lo, hi);
  endtask : rd

  function automatic logic [31:0] ctl(input int md, input int cs, input int cl,
                                      input int rn, input int ie, input int pd);
    ctl = (md << CTL_MODE) | (cs << CTL_CSEL_LO) | (cl << CTL_CLR) | (rn << CTL_RUN)
        | (ie << CTL_IE) | (pd << CTL_PEND);
  endfunction : ctl

  task automatic wait_irq;
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge hclk);
      if (irq === 1'b1) return;
    end
    n_errors++;
    end_sim();
  endtask : wait_irq

  initial begin
    logic [31:0] v;
    int          t;
    int          d;
    logic [7:0]  idx;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (divs[k]) rd(IDX_CTL_A + 8'(k), 32'h0, 32'h0);
    rd(IDX_MASK, 32'h0, 32'h0);
    wr(IDX_CTL_B, 32'hff);
    rd(IDX_CTL_B, ctl(0, 3, 0, 1, 1, 0), ctl(0, 3, 0, 1, 1, 0));
    wr(IDX_CTL_B, 32'h0);
    wr(IDX_CTL_A, ctl(0, 0, 1, 0, 0, 0) | (1 << CTL_RSV));
    rd(IDX_CTL_A, 32'h40, 32'h40);
    wr(IDX_CTL_A, 32'h0);
    v = $random(seed);
    wr(IDX_MASK, v);
    rd(IDX_MASK, v & 32'h3, v & 32'h3);
    wr(8'hd7, $random(seed));
    rd(8'hd7, 32'h0, 32'h0);
    $display("test reset_access done");
    for (t = 0; t < 2; t++) begin
      for (d = 0; d < 4; d++) begin
        idx = t ? IDX_CTL_B : IDX_CTL_A;
        wr(IDX_CTL_A, ctl(0, 0, 1, 0, 0, 0));
        wr(IDX_CTL_B, ctl(0, 0, 1, 0, 0, 0));
        wr(idx, ctl(0, d, 0, 1, 0, 0));
        repeat (3 * divs[d]) @(posedge hclk);
        wr(idx, ctl(0, d, 0, 0, 0, 0));
        repeat (20) @(posedge hclk);
        rd(IDX_COUNT, 32'(3) << (8 * t), 32'((3 * divs[d] + 4) / divs[d] + 1) << (8 * t));
      end
    end
    $display("test clock_select done");
    wr(IDX_CTL_A, ctl(1, 3, 1, 1, 0, 0));
    repeat (300) @(posedge hclk);
    wr(IDX_CTL_A, ctl(1, 3, 0, 0, 0, 0));
    rd(IDX_COUNT, 32'd300, 32'd310);
    wr(IDX_CTL_A, 32'h0);
    $display("test joined_mode done");
    wr(IDX_MASK, 32'h3);
    wr(IDX_CTL_A, ctl(0, 3, 1, 1, 1, 0));
    wait_irq();
    wr(IDX_CTL_A, ctl(0, 3, 0, 0, 1, 1));
    rd(IDX_CTL_A, ctl(0, 3, 0, 0, 1, 1), ctl(0, 3, 0, 0, 1, 1));
    rd(IDX_STATUS, 32'h1, 32'h1);
    wr(IDX_MASK, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, 32'h0);
    wr(IDX_MASK, 32'h3);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1, 32'h1);
    wr(IDX_CTL_A, ctl(0, 3, 0, 0, 1, 0));
    rd(IDX_CTL_A, ctl(0, 3, 0, 0, 1, 0), ctl(0, 3, 0, 0, 1, 0));
    wr(IDX_STATUS, 32'h1);
    rd(IDX_STATUS, 32'h0, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, 32'h0);
    wr(IDX_CTL_B, ctl(0, 3, 1, 1, 0, 0));
    repeat (300) @(posedge hclk);
    wr(IDX_CTL_B, ctl(0, 3, 0, 0, 0, 1));
    rd(IDX_CTL_B, ctl(0, 3, 0, 0, 0, 1), ctl(0, 3, 0, 0, 0, 1));
    rd(IDX_STATUS, 32'h0, 32'h0);
    chk({31'h0, irq}, 32'h0, 32'h0);
    $display("test interrupt done");
    repeat (4) @(posedge hclk);
    end_sim();
  end
endmodule : test_dual_8bit_timer_control
`default_nettype wire
